// ---- vlan_acl_pkg.sv ----
// Purpose: shared constants and carriers for the vlan/acl table access block
// Assumes: 16-bit register data, 16-bit byte addresses, port n in addr[15:12]
// Notes:   narrower registers sit in the low bits, upper bits read zero
`default_nettype none
package vlan_acl_pkg;
  localparam int VLAN_ENTRIES  = 4096;
  localparam int VID_W         = 12;
  localparam int ACL_ENTRIES   = 16;
  localparam int ACL_BYTES     = 16;
  localparam int ACL_UNUSED    = 12;
  localparam int MAX_PORTS     = 7;
  localparam int DATA_W        = 16;
  localparam int ADDR_W        = 16;
  localparam int ALU_IDX_W     = 12;

  // global vlan access registers
  localparam logic [15:0] VLAN_ENTRY0_ADDR = 16'h0410;
  localparam logic [15:0] VLAN_ENTRY1_ADDR = 16'h0411;
  localparam logic [15:0] VLAN_ENTRY2_ADDR = 16'h0412;
  localparam logic [15:0] VLAN_INDEX_ADDR  = 16'h0413;
  localparam logic [15:0] VLAN_CTRL_ADDR   = 16'h0414;
  localparam logic [15:0] LOOKUP_CTRL_ADDR = 16'h0415;
  localparam int VLAN_START_BIT  = 7;
  localparam int VLAN_READ_BIT   = 0;
  localparam int QMODE_BIT       = 0;
  localparam int UNTAG_LSB       = 8;

  // per-port acl window, offsets within 0xN6xx
  localparam logic [3:0] ACL_WIN_NIB    = 4'h6;
  localparam logic [7:0] ACL_DATA_LAST  = 8'h0F;
  localparam logic [7:0] ACL_BE_MSB_OFS = 8'h10;
  localparam logic [7:0] ACL_BE_LSB_OFS = 8'h11;
  localparam logic [7:0] ACL_CTRL0_OFS  = 8'h12;
  localparam int ACL_WR_BIT      = 4;
  localparam int ACL_RD_DONE_BIT = 5;
  localparam int ACL_WR_DONE_BIT = 6;

  localparam logic [7:0]  VLAN_CTRL_RST = 8'h00;
  localparam logic [15:0] ACL_BE_RST    = 16'h0000;
  localparam logic [6:0]  DEFAULT_FWD   = 7'h7F;

  typedef struct packed {
    logic       valid;
    logic       fwd_opt;
    logic [2:0] prio;
    logic [2:0] mstp_index;
    logic [6:0] filter_identifier;
    logic [6:0] untag;
    logic [6:0] member;
  } vlan_entry_t;

  typedef struct packed {
    logic        vld;
    logic [11:0] vid;
    logic [47:0] dest_addr;
  } lookup_req_t;

  typedef struct packed {
    logic        vld;
    logic        entry_valid;
    logic        member_fwd;
    logic [6:0]  fwd_ports;
    logic [6:0]  untag;
    logic [2:0]  prio;
    logic [2:0]  mstp_index;
    logic [11:0] alu_index;
  } lookup_res_t;

  typedef enum {VT_IDLE, VT_BUSY} vlan_state_t;
endpackage : vlan_acl_pkg
`default_nettype wire

// ---- vlan_acl_table_access.sv ----
// Purpose: indirect access to the vlan table and per-port acl tables
// Assumes: one clock, single management master on a plain register port
// Notes:   vlan lookup result is registered, one cycle after the request
//
// Behaviour
// [RQ1] 4096-entry vlan array indexed directly by the vid value.
// [RQ2] with 802.1q mode on, each ingress vid fetches its vlan entry.
// [RQ3] software fills the vlan table before enabling 802.1q mode.
// [RQ4] entry holds valid, forward option, priority, mstp, filter id, untag.
// [RQ5] forward option one uses membership; zero gives default forwarding.
// [RQ6] filter id combined with destination address, hashed to an index.
// [RQ7] untag bit one strips the tag; port 1 at lsb.
// [RQ8] member bit one includes the port, zero excludes; port 1 at lsb.
// [RQ9] 12-bit index selects the entry; entry regs loaded before command.
// [RQ10] control bit 7 starts a transfer and clears itself when done.
// [RQ11] vlan read leaves the entry in the three entry registers.
// [RQ12] each port owns a 16-entry acl table reached via an index.
// [RQ13] acl registers of port n live at 0xN600 to 0xN6FF.
// [RQ14] byte enable bit i gates data byte 15-i.
// [RQ15] any combination of enabled bytes may be transferred.
// [RQ16] data byte c is unused; its enable bit 3 is ignored.
// [RQ17] bytes 0xN60A and 0xN60B hold the priority and mirror action bits.
// [RQ18] rule group vector upper byte at 0xN60E, lower at 0xN60F.
// [RQ19] control 0 write with bit 4 clear starts a read; status shows done.
// [RQ20] control 0 write with bit 4 set writes enabled bytes; status done.
// [RQ21] software waits for start to clear before touching vlan regs.
`timescale 1ns/1ps
`default_nettype none
module vlan_acl_table_access #(
  parameter int NUM_PORTS = 3
) (
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic [15:0]               addr,
  input  wire logic [15:0]               wdata,
  input  wire logic                      wr_stb,
  input  wire logic                      rd_stb,
  output var  logic [15:0]               rdata,
  input  wire vlan_acl_pkg::lookup_req_t lookup_req,
  output var  vlan_acl_pkg::lookup_res_t lookup_res
);
  import vlan_acl_pkg::*;

  if (NUM_PORTS < 1 || NUM_PORTS > MAX_PORTS) begin : g_bad_ports
    $error("NUM_PORTS must lie between 1 and 7");
  end

  // hash of filter id and destination address into the lookup index
  function automatic logic [ALU_IDX_W-1:0] alu_hash(
    input logic [6:0]  flt_id,
    input logic [47:0] da
  );
    logic [59:0]           v;
    logic [ALU_IDX_W-1:0]  h;
    v = {5'h00, flt_id, da};
    h = '0;
    for (int i = 0; i < 5; i++) begin
      h = h ^ v[i*ALU_IDX_W +: ALU_IDX_W];
    end
    return h;
  endfunction : alu_hash

  localparam logic [NUM_PORTS-1:0] PORT_MASK = '1;
  localparam logic [6:0] PORT_MASK7 = 7'(PORT_MASK);

  // vlan access registers
  vlan_entry_t           vlan_entry_r;
  logic [VID_W-1:0]      vlan_index_r;
  logic [7:0]            vlan_ctrl_r;
  logic                  qmode_r;
  vlan_state_t           vt_state_r;
  vlan_state_t           vt_state_nxt;
  lookup_res_t           lookup_res_r;
  logic [15:0]           rdata_r;

  // [RQ1] direct vid array
  vlan_entry_t vlan_mem [VLAN_ENTRIES];

  wire wr_entry0 = wr_stb && (addr == VLAN_ENTRY0_ADDR);
  wire wr_entry1 = wr_stb && (addr == VLAN_ENTRY1_ADDR);
  wire wr_entry2 = wr_stb && (addr == VLAN_ENTRY2_ADDR);
  wire wr_index  = wr_stb && (addr == VLAN_INDEX_ADDR);
  wire wr_vctrl  = wr_stb && (addr == VLAN_CTRL_ADDR);
  wire wr_qctrl  = wr_stb && (addr == LOOKUP_CTRL_ADDR);
  wire vt_idle   = (vt_state_r == VT_IDLE);
  // [RQ10] start only from idle, so a busy transfer is never disturbed
  wire vt_launch = wr_vctrl && vt_idle && wdata[VLAN_START_BIT];
  wire vt_read   = vlan_ctrl_r[VLAN_READ_BIT];
  wire vt_done   = (vt_state_r == VT_BUSY);

  assign vt_state_nxt = vt_launch ? VT_BUSY :
                        vt_done   ? VT_IDLE : vt_state_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vt_state_r <= VT_IDLE;
    end else begin
      vt_state_r <= vt_state_nxt;
    end
  end

  // [RQ10] start bit self-clears as the transfer finishes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vlan_ctrl_r <= VLAN_CTRL_RST;
    end else if (vt_launch) begin
      vlan_ctrl_r <= wdata[7:0];
    end else if (vt_done) begin
      vlan_ctrl_r[VLAN_START_BIT] <= 1'b0;
    end else if (wr_vctrl && vt_idle) begin
      vlan_ctrl_r <= wdata[7:0];
    end
  end

  // [RQ9] 12-bit entry selector
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vlan_index_r <= '0;
      qmode_r      <= 1'b0;
    end else begin
      if (wr_index) begin
        vlan_index_r <= wdata[VID_W-1:0];
      end
      if (wr_qctrl) begin
        qmode_r <= wdata[QMODE_BIT];
      end
    end
  end

  // [RQ4] entry field layout over three registers
  // [RQ11] a finished read overrides a software write in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vlan_entry_r <= '0;
    end else if (vt_done && vt_read) begin
      vlan_entry_r <= vlan_mem[vlan_index_r];
    end else begin
      if (wr_entry0) begin
        vlan_entry_r.valid      <= wdata[7];
        vlan_entry_r.fwd_opt    <= wdata[6];
        vlan_entry_r.prio       <= wdata[5:3];
        vlan_entry_r.mstp_index <= wdata[2:0];
      end
      if (wr_entry1) begin
        vlan_entry_r.filter_identifier <= wdata[6:0];
      end
      if (wr_entry2) begin
        vlan_entry_r.untag  <= wdata[UNTAG_LSB +: 7];
        vlan_entry_r.member <= wdata[6:0];
      end
    end
  end

  // table contents carry no reset; software must fill before use
  always_ff @(posedge clk) begin
    // [RQ9] write commits the staged entry at the index
    if (vt_done && !vt_read) begin
      vlan_mem[vlan_index_r] <= vlan_entry_r;
    end
  end

  // [RQ2] lookup only while 802.1q mode is on
  wire         lk_go = lookup_req.vld && qmode_r;
  vlan_entry_t lk_entry;
  assign lk_entry = vlan_mem[lookup_req.vid];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lookup_res_r <= '0;
    end else begin
      lookup_res_r.vld         <= lk_go;
      lookup_res_r.entry_valid <= lk_go && lk_entry.valid;
      // fields hold between lookups so idle cycles never show stray rows
      if (lk_go) begin
        lookup_res_r.member_fwd  <= lk_entry.fwd_opt;
        // [RQ5] membership or default forwarding
        // [RQ8] member bits map port 1 to lsb
        lookup_res_r.fwd_ports   <= (lk_entry.fwd_opt ? lk_entry.member
                                                      : DEFAULT_FWD)
                                    & PORT_MASK7;
        // [RQ7] reserved untag bits never reach a port
        lookup_res_r.untag       <= lk_entry.untag & PORT_MASK7;
        lookup_res_r.prio        <= lk_entry.prio;
        lookup_res_r.mstp_index  <= lk_entry.mstp_index;
        // [RQ6] filter id plus destination hashed
        lookup_res_r.alu_index   <= alu_hash(lk_entry.filter_identifier,
                                             lookup_req.dest_addr);
      end
    end
  end

  // vlan side read data
  wire [15:0] vlan_rd =
    (addr == VLAN_ENTRY0_ADDR) ? {8'h00, vlan_entry_r.valid,
                                  vlan_entry_r.fwd_opt, vlan_entry_r.prio,
                                  vlan_entry_r.mstp_index} :
    (addr == VLAN_ENTRY1_ADDR) ? {9'h000, vlan_entry_r.filter_identifier} :
    (addr == VLAN_ENTRY2_ADDR) ? {1'b0, vlan_entry_r.untag,
                                  1'b0, vlan_entry_r.member} :
    (addr == VLAN_INDEX_ADDR)  ? {4'h0, vlan_index_r} :
    (addr == VLAN_CTRL_ADDR)   ? {8'h00, vlan_ctrl_r} :
    (addr == LOOKUP_CTRL_ADDR) ? {15'h0000, qmode_r} : 16'h0000;

  // per-port acl tables
  logic [15:0] acl_or [NUM_PORTS+1];
  assign acl_or[0] = 16'h0000;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    localparam logic [3:0] PNUM = 4'(p + 1);
    // [RQ13] window 0xN600-0xN6FF for port n
    wire       win_hit = (addr[15:12] == PNUM) && (addr[11:8] == ACL_WIN_NIB);
    wire [7:0] ofs     = addr[7:0];
    wire       wr_win  = wr_stb && win_hit;
    wire       wr_bem  = wr_win && (ofs == ACL_BE_MSB_OFS);
    wire       wr_bel  = wr_win && (ofs == ACL_BE_LSB_OFS);
    wire       wr_ctl  = wr_win && (ofs == ACL_CTRL0_OFS);

    logic [7:0]  data_r [ACL_BYTES];
    logic [15:0] be_r;
    logic [3:0]  idx_r;
    logic        wr_op_r;
    logic        pend_r;
    logic        rd_done_r;
    logic        wr_done_r;

    // commands arriving mid-operation are dropped
    wire launch = wr_ctl && !pend_r;

    // [RQ19] read starts on control 0 write with bit 4 clear
    // [RQ20] write starts on control 0 write with bit 4 set
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        idx_r     <= '0;
        wr_op_r   <= 1'b0;
        pend_r    <= 1'b0;
        rd_done_r <= 1'b0;
        wr_done_r <= 1'b0;
      end else if (launch) begin
        idx_r     <= wdata[3:0];
        wr_op_r   <= wdata[ACL_WR_BIT];
        pend_r    <= 1'b1;
        rd_done_r <= 1'b0;
        wr_done_r <= 1'b0;
      end else if (pend_r) begin
        pend_r    <= 1'b0;
        rd_done_r <= !wr_op_r;
        wr_done_r <= wr_op_r;
      end
    end

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        be_r <= ACL_BE_RST;
      end else begin
        if (wr_bem) begin
          be_r[15:8] <= wdata[7:0];
        end
        if (wr_bel) begin
          be_r[7:0] <= wdata[7:0];
        end
      end
    end

    wire [7:0] byte_rd [ACL_BYTES];

    for (genvar k = 0; k < ACL_BYTES; k++) begin : g_byte
      if (k == ACL_UNUSED) begin : g_unused
        // [RQ16] byte c has no storage, enable bit 3 unused
        assign byte_rd[k] = 8'h00;
      end else begin : g_used
        // [RQ14] reversed enable order
        // [RQ15] each byte gated on its own
        wire en    = be_r[ACL_BYTES-1-k];
        wire wr_sw = wr_win && (ofs == 8'(k));
        // [RQ12] sixteen entries per port behind the index
        // one column per byte keeps each table word single-driven
        logic [7:0] col_mem [ACL_ENTRIES];
        // [RQ17] action bytes a and b stored whole like any other
        // [RQ18] rule group vector bytes e and f likewise
        always_ff @(posedge clk or negedge arst_n) begin
          if (!arst_n) begin
            data_r[k] <= 8'h00;
          end else if (pend_r && !wr_op_r && en) begin
            data_r[k] <= col_mem[idx_r];
          end else if (wr_sw) begin
            data_r[k] <= wdata[7:0];
          end
        end
        always_ff @(posedge clk) begin
          if (pend_r && wr_op_r && en) begin
            col_mem[idx_r] <= data_r[k];
          end
        end
        assign byte_rd[k] = data_r[k];
      end
    end

    wire [7:0] ctl_rd = {1'b0, wr_done_r, rd_done_r, wr_op_r, idx_r};
    wire [15:0] port_rd =
      !win_hit                 ? 16'h0000 :
      (ofs <= ACL_DATA_LAST)   ? {8'h00, byte_rd[ofs[3:0]]} :
      (ofs == ACL_BE_MSB_OFS)  ? {8'h00, be_r[15:8]} :
      (ofs == ACL_BE_LSB_OFS)  ? {8'h00, be_r[7:0]} :
      (ofs == ACL_CTRL0_OFS)   ? {8'h00, ctl_rd} : 16'h0000;
    assign acl_or[p+1] = acl_or[p] | port_rd;
  end

  // read data stands one cycle only, zero otherwise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rd_stb ? (vlan_rd | acl_or[NUM_PORTS]) : 16'h0000;
    end
  end

  assign rdata      = rdata_r;
  assign lookup_res = lookup_res_r;
endmodule : vlan_acl_table_access
`default_nettype wire

// ---- vlan_acl_table_access_sva.sv ----
// Purpose: port-level checks for the vlan/acl table access block
// Assumes: single clock, async active-low reset
// Notes:   table contents are hidden, so reads are tied to commands
`timescale 1ns/1ps
`default_nettype none
module vlan_acl_table_access_chk
  import vlan_acl_pkg::*;
#(
  parameter int NUM_PORTS = 3
) (
  input wire logic                      clk,
  input wire logic                      arst_n,
  input wire logic [15:0]               addr,
  input wire logic [15:0]               wdata,
  input wire logic                      wr_stb,
  input wire logic                      rd_stb,
  input wire logic [15:0]               rdata,
  input wire vlan_acl_pkg::lookup_req_t lookup_req,
  input wire vlan_acl_pkg::lookup_res_t lookup_res
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  localparam logic [6:0] PORT_MASK = 7'((1 << NUM_PORTS) - 1);
  sequence vlan_start_s;
    wr_stb && addr == VLAN_CTRL_ADDR && wdata[VLAN_START_BIT];
  endsequence
  sequence vlan_poll_s;
    rd_stb && addr == VLAN_CTRL_ADDR;
  endsequence
  sequence acl_cmd_s;
    wr_stb && addr[11:0] == {ACL_WIN_NIB, ACL_CTRL0_OFS} &&
    addr[15:12] != 4'h0 && addr[15:12] <= NUM_PORTS;
  endsequence
  sequence acl_poll_s;
    rd_stb && addr[11:0] == {ACL_WIN_NIB, ACL_CTRL0_OFS};
  endsequence
  rdata_idle_a: assert property (!rd_stb |=> rdata == 16'h0000)
    else $error("read data not zero outside read cycle");
  byte_c_zero_a: assert property (rd_stb && addr[11:0] == 12'h60C |=>
    rdata == 16'h0000) else $error("unused acl byte read nonzero");
  port0_window_a: assert property (rd_stb && addr[15:8] == 8'h06 |=>
    rdata == 16'h0000) else $error("port zero acl window answered");
  vlan_clear_a: assert property (vlan_start_s ##2 vlan_poll_s |=>
    !rdata[VLAN_START_BIT]) else $error("vlan start bit not cleared");
  acl_done_a: assert property (acl_cmd_s ##2 acl_poll_s ##0
    addr == $past(addr, 2) |=> rdata[6:5] != 2'b00)
    else $error("acl done status missing");
  acl_ctrl_bits_a: assert property (acl_poll_s |=>
    rdata[15:7] == 9'h000) else $error("acl control upper bits nonzero");
  res_cause_a: assert property (!lookup_req.vld |=> !lookup_res.vld)
    else $error("lookup result without request");
  fwd_mask_a: assert property (lookup_res.vld |->
    (lookup_res.fwd_ports & ~PORT_MASK) == 7'h00)
    else $error("forward ports beyond port count");
  untag_mask_a: assert property (lookup_res.vld |->
    (lookup_res.untag & ~PORT_MASK) == 7'h00)
    else $error("untag bits beyond port count");
  default_fwd_a: assert property (lookup_res.vld &&
    !lookup_res.member_fwd |-> lookup_res.fwd_ports == PORT_MASK)
    else $error("default forwarding not all ports");
  hold_fields_a: assert property (!lookup_req.vld |=>
    $stable(lookup_res.alu_index) && $stable(lookup_res.prio))
    else $error("lookup fields changed without request");
endmodule : vlan_acl_table_access_chk
bind vlan_acl_table_access vlan_acl_table_access_chk #(
  .NUM_PORTS(NUM_PORTS)
) chk_inst (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .lookup_req(lookup_req), .lookup_res(lookup_res));
`default_nettype wire

// ---- vlan_acl_table_access_test.sv ----
// Purpose: self-checking bench for the vlan/acl table access block
// Assumes: three ports, acl traffic on port 2
// Notes:   fixed waits follow the two-edge completion of each transfer
`timescale 1ns/1ps
`default_nettype none
module vlan_acl_table_access_test;
  import vlan_acl_pkg::*;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [15:0] rdata;
  lookup_req_t lookup_req = '0;
  lookup_res_t lookup_res;
  int          n_mismatch = 0;
  int          checks_done = 0;
  always #2 clk = ~clk;
  vlan_acl_table_access #(.NUM_PORTS(3)) vlan_acl_table_access_inst (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .lookup_req(lookup_req), .lookup_res(lookup_res));
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [15:0] a, logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rc(string name, logic [15:0] a, logic [15:0] exp);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    // read data stands only until the next edge
    #1;
    chk(name, rdata, exp);
    @(posedge clk);
  endtask : rc
  task automatic vput(logic [15:0] idx, logic [15:0] e0, logic [15:0] e1,
                      logic [15:0] e2);
    wr(VLAN_ENTRY0_ADDR, e0);
    wr(VLAN_ENTRY1_ADDR, e1);
    wr(VLAN_ENTRY2_ADDR, e2);
    wr(VLAN_INDEX_ADDR, idx);
    wr(VLAN_CTRL_ADDR, 16'h0080);
    rc("vlan_wr_ctrl", VLAN_CTRL_ADDR, 16'h0000);
  endtask : vput
  task automatic look(logic [11:0] v);
    lookup_req <= '{vld: 1'b1, vid: v, dest_addr: 48'h1234_5678_9ABC};
    @(posedge clk);
    lookup_req <= '0;
    #1;
  endtask : look
  function automatic logic [15:0] pat(int i);
    // bytes b and d get values with only their upper bits set
    return (i == 11) ? 16'h00E0 : (i == 13) ? 16'h0060 : 16'h0010 + 16'(i);
  endfunction : pat
  task automatic t_reset;
    rc("vlan_ctrl_rst", VLAN_CTRL_ADDR, 16'h0000);
    rc("mode_rst", LOOKUP_CTRL_ADDR, 16'h0000);
    rc("be_rst", 16'h2611, 16'h0000);
    rc("acl_ctrl_rst", 16'h1612, 16'h0000);
  endtask : t_reset
  task automatic t_vlan;
    vput(16'h0FFF, 16'h00EB, 16'h002A, 16'h7E7D);
    vput(16'h0000, 16'h0080, 16'h0000, 16'h0102);
    // clear the holding registers so the read must refill them
    wr(VLAN_ENTRY0_ADDR, 16'h0000);
    wr(VLAN_ENTRY1_ADDR, 16'h0000);
    wr(VLAN_ENTRY2_ADDR, 16'h0000);
    wr(VLAN_INDEX_ADDR, 16'h0FFF);
    wr(VLAN_CTRL_ADDR, 16'h0081);
    rc("vlan_rd_ctrl", VLAN_CTRL_ADDR, 16'h0001);
    rc("entry0", VLAN_ENTRY0_ADDR, 16'h00EB);
    rc("entry1", VLAN_ENTRY1_ADDR, 16'h002A);
    rc("entry2", VLAN_ENTRY2_ADDR, 16'h7E7D);
  endtask : t_vlan
  task automatic t_lookup;
    look(12'hFFF);
    chk("vld_off", 16'(lookup_res.vld), 16'h0000);
    @(posedge clk);
    wr(LOOKUP_CTRL_ADDR, 16'h0001);
    look(12'hFFF);
    chk("vld_on", 16'(lookup_res.vld), 16'h0001);
    chk("fwd_member", 16'(lookup_res.fwd_ports), 16'h0005);
    chk("untag", 16'(lookup_res.untag), 16'h0006);
    chk("vld_prio_mstp", 16'({lookup_res.entry_valid, lookup_res.prio,
        lookup_res.mstp_index}), 16'h006B);
    chk("alu_index", 16'(lookup_res.alu_index), 16'h086A);
    @(posedge clk);
    look(12'h000);
    chk("fwd_default", 16'({lookup_res.member_fwd, lookup_res.fwd_ports}),
        16'h0007);
    chk("untag_p1", 16'(lookup_res.untag), 16'h0001);
    chk("alu_index_f0", 16'(lookup_res.alu_index), 16'h0840);
    @(posedge clk);
    wr(LOOKUP_CTRL_ADDR, 16'h0000);
  endtask : t_lookup
  task automatic t_acl;
    for (int i = 0; i < 16; i++) wr(16'h2600 + 16'(i), pat(i));
    wr(16'h2610, 16'h00FF);
    wr(16'h2611, 16'h00FF);
    wr(16'h2612, 16'h0015);
    rc("acl_wr_done", 16'h2612, 16'h0055);
    for (int i = 0; i < 16; i++) wr(16'h2600 + 16'(i), 16'h00EE);
    // only enable bit 0, which must land on the last byte
    wr(16'h2610, 16'h0000);
    wr(16'h2611, 16'h0001);
    wr(16'h2612, 16'h0015);
    rc("acl_part_done", 16'h2612, 16'h0055);
    wr(16'h2610, 16'h00FF);
    wr(16'h2611, 16'h00FF);
    wr(16'h2612, 16'h0005);
    rc("acl_rd_done", 16'h2612, 16'h0025);
    for (int i = 0; i < 16; i++) begin
      rc("acl_byte", 16'h2600 + 16'(i), (i == 15) ? 16'h00EE :
         (i == 12) ? 16'h0000 : pat(i));
    end
    rc("unmapped", 16'h0416, 16'h0000);
    rc("port0_win", 16'h0612, 16'h0000);
    rc("other_port", 16'h1612, 16'h0000);
  endtask : t_acl
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_vlan();
    t_lookup();
    t_acl();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule : vlan_acl_table_access_test
`default_nettype wire
